// [pei_event_irq.sv]
// Purpose: Latched event status, per-event enables and interrupt output
// Assumes: Event inputs are one-cycle pulses on aclk from PHY logic
// Notes:   Status bits clear on read of their register
//          Events share aclk, so they pass no synchroniser
//          A set in the clearing read's cycle survives that read
//
// What this block does
// - Link-quality-low status bit 15, enable bit 7
// - Link-quality enable gates its interrupt contribution
// - Energy-detect change status 14, enable 6
// - Link change status 13, enable 5
// - ESD fault status 11, enable 3
// - Training done status 10, enable 2
// - Undervoltage status 15, enable 7, register two
// - Overvoltage status 14, enable 6, register two
// - Overtemperature status 11, enable 3, register two
// - Sleep change status 10, enable 2
// - One-hot violation status bit 8, no enable
// - Ops acknowledge status 15, enable 7
// - Transmit-pending clear status 14, enable 6
// - Power-up done status 11, enable 3 resets one
// - No-frame status 10, enable 2
// - Wake status 9/1, low-power-sleep status 8/0
// - Registers one and two at 0x12, 0x13
// - Register three at 0x18, resets 0x8
// - Global enable gates all event interrupt reporting, not the force bit
// - Force bit drives interrupt pin active
`timescale 1ns/10ps
module pei_event_irq
  import pei_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [PEI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [PEI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event pulses from PHY logic
  input wire pei_events_s events,
  // Interrupt toward host, active high
  output logic irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] ev1_r;
  logic [15:0] ev2_r;
  logic [15:0] ev3_r;
  logic [15:0] cfg_r;
  logic [15:0] ev1_nxt;
  logic [15:0] ev2_nxt;
  logic [15:0] ev3_nxt;
  logic [15:0] cfg_nxt;

  // ----------------------------------------------------------------
  // Bus channel state
  // ----------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [PEI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ----------------------------------------------------------------
  // Interrupt state
  // ----------------------------------------------------------------
  logic irq_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] pei_decode(input logic [PEI_AW-1:0] a);
    logic [2:0] sel;
    sel = 3'h0;
    case (a)
      PEI_ADDR_EV1: sel = 3'h1;
      PEI_ADDR_EV2: sel = 3'h2;
      PEI_ADDR_EV3: sel = 3'h3;
      PEI_ADDR_CFG: sel = 3'h4;
      default: sel = 3'h0;
    endcase
    return sel;
  endfunction : pei_decode

  // Unmapped addresses are refused; mapped ones answer OKAY
  function automatic logic [1:0] pei_resp(input logic [2:0] sel);
    logic [1:0] resp;
    resp = PEI_RESP_OKAY;
    if (sel == 3'h0) begin
      resp = PEI_RESP_SLVERR;
    end
    return resp;
  endfunction : pei_resp

  // ----------------------------------------------------------------
  // Bus handshakes and selects
  // ----------------------------------------------------------------
  // Write is done once both address and data are held and no write response is pending
  wire logic wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire logic [2:0] wr_sel = pei_decode(awaddr_r);
  wire logic rd_fire = s_axi_arvalid && !rvalid_r;
  wire logic [2:0] rd_sel = pei_decode(s_axi_araddr);

  // ----------------------------------------------------------------
  // Write strobe lanes
  // ----------------------------------------------------------------
  // Only the two low byte lanes reach a 16-bit register
  logic [15:0] wr_lo;
  logic [15:0] wr_keep;
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign wr_lo[8*g+7:8*g] = wstrb_r[g] ? wdata_r[8*g+7:8*g] : 8'h00;
    assign wr_keep[8*g+7:8*g] = {8{~wstrb_r[g]}};
  end

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  wire logic [15:0] ev1_set = {events.link_quality_low,
                               events.energy_detect_change,
                               events.link_change,
                               1'b0,
                               events.esd_fault,
                               events.training_done,
                               10'h000};
  wire logic [15:0] ev2_set = {events.undervoltage,
                               events.overvoltage,
                               2'h0,
                               events.overtemperature,
                               events.sleep_change,
                               1'b0,
                               events.not_one_hot,
                               8'h00};
  wire logic [15:0] ev3_set = {events.ops_ack_received,
                               events.ops_channel_transmit_pending_clr,
                               2'h0,
                               events.power_up_done,
                               events.no_frame,
                               events.wake_request,
                               events.low_power_sleep_signal,
                               8'h00};

  // ----------------------------------------------------------------
  // Clear and write strobes per register
  // ----------------------------------------------------------------
  // Read clears status; a new event in the same cycle wins over the clear
  wire logic rd_clr1 = rd_fire && (rd_sel == 3'h1);
  wire logic rd_clr2 = rd_fire && (rd_sel == 3'h2);
  wire logic rd_clr3 = rd_fire && (rd_sel == 3'h3);
  wire logic wr1 = wr_fire && (wr_sel == 3'h1);
  wire logic wr2 = wr_fire && (wr_sel == 3'h2);
  wire logic wr3 = wr_fire && (wr_sel == 3'h3);
  wire logic wr4 = wr_fire && (wr_sel == 3'h4);

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  // Enables written, status bits only by hardware, reserved stay zero
  assign ev1_nxt = ((rd_clr1 ? 16'h0000 : ev1_r & PEI_EV1_STS) | ev1_set)
                 | ((wr1 ? (ev1_r & wr_keep) | wr_lo : ev1_r)
                    & PEI_EV1_EN);
  assign ev2_nxt = ((rd_clr2 ? 16'h0000 : ev2_r & PEI_EV2_STS) | ev2_set)
                 | ((wr2 ? (ev2_r & wr_keep) | wr_lo : ev2_r)
                    & PEI_EV2_EN);
  assign ev3_nxt = ((rd_clr3 ? 16'h0000 : ev3_r & PEI_EV3_STS) | ev3_set)
                 | ((wr3 ? (ev3_r & wr_keep) | wr_lo : ev3_r)
                    & PEI_EV3_EN);
  assign cfg_nxt = (wr4 ? (cfg_r & wr_keep) | wr_lo : cfg_r) & PEI_CFG_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev1_r <= PEI_EV1_RST;
    end else begin
      ev1_r <= ev1_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev2_r <= PEI_EV2_RST;
    end else begin
      ev2_r <= ev2_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev3_r <= PEI_EV3_RST;
    end else begin
      ev3_r <= ev3_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= PEI_CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Per-event status views
  // ----------------------------------------------------------------
  wire logic st_lq = ev1_r[15];
  wire logic st_edet = ev1_r[14];
  wire logic st_lchg = ev1_r[13];
  wire logic st_esd = ev1_r[11];
  wire logic st_train = ev1_r[10];
  wire logic st_uvolt = ev2_r[15];
  wire logic st_ovolt = ev2_r[14];
  wire logic st_otemp = ev2_r[11];
  wire logic st_sleep = ev2_r[10];
  wire logic st_onehot = ev2_r[PEI_ONEHOT_BIT];
  wire logic st_ack = ev3_r[15];
  wire logic st_txclr = ev3_r[14];
  wire logic st_pwrup = ev3_r[11];
  wire logic st_noframe = ev3_r[10];
  wire logic st_wake = ev3_r[9];
  wire logic st_lowpwr = ev3_r[8];

  // ----------------------------------------------------------------
  // Per-event enable views
  // ----------------------------------------------------------------
  // Each enable sits one byte below its status bit
  wire logic en_lq = ev1_r[15-PEI_EN_SHIFT];
  wire logic en_edet = ev1_r[14-PEI_EN_SHIFT];
  wire logic en_lchg = ev1_r[13-PEI_EN_SHIFT];
  wire logic en_esd = ev1_r[11-PEI_EN_SHIFT];
  wire logic en_train = ev1_r[10-PEI_EN_SHIFT];
  wire logic en_uvolt = ev2_r[15-PEI_EN_SHIFT];
  wire logic en_ovolt = ev2_r[14-PEI_EN_SHIFT];
  wire logic en_otemp = ev2_r[11-PEI_EN_SHIFT];
  wire logic en_sleep = ev2_r[10-PEI_EN_SHIFT];
  wire logic en_ack = ev3_r[15-PEI_EN_SHIFT];
  wire logic en_txclr = ev3_r[14-PEI_EN_SHIFT];
  wire logic en_pwrup = ev3_r[11-PEI_EN_SHIFT];
  wire logic en_noframe = ev3_r[10-PEI_EN_SHIFT];
  wire logic en_wake = ev3_r[9-PEI_EN_SHIFT];
  wire logic en_lowpwr = ev3_r[8-PEI_EN_SHIFT];

  // ----------------------------------------------------------------
  // Interrupt causes
  // ----------------------------------------------------------------
  // One-hot check has no enable of its own, so only the global enable gates it
  wire logic hit_lq = st_lq && en_lq;
  wire logic hit_edet = st_edet && en_edet;
  wire logic hit_lchg = st_lchg && en_lchg;
  wire logic hit_esd = st_esd && en_esd;
  wire logic hit_train = st_train && en_train;
  wire logic hit_uvolt = st_uvolt && en_uvolt;
  wire logic hit_ovolt = st_ovolt && en_ovolt;
  wire logic hit_otemp = st_otemp && en_otemp;
  wire logic hit_sleep = st_sleep && en_sleep;
  wire logic hit_onehot = st_onehot;
  wire logic hit_ack = st_ack && en_ack;
  wire logic hit_txclr = st_txclr && en_txclr;
  wire logic hit_pwrup = st_pwrup && en_pwrup;
  wire logic hit_noframe = st_noframe && en_noframe;
  wire logic hit_wake = st_wake && en_wake;
  wire logic hit_lowpwr = st_lowpwr && en_lowpwr;
  wire logic any_act = hit_lq || hit_edet || hit_lchg || hit_esd
                     || hit_train || hit_uvolt || hit_ovolt || hit_otemp
                     || hit_sleep || hit_onehot || hit_ack || hit_txclr
                     || hit_pwrup || hit_noframe || hit_wake
                     || hit_lowpwr;

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  wire logic gie = cfg_r[PEI_CFG_GIE_BIT];
  wire logic force_pin = cfg_r[PEI_CFG_FORCE_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= force_pin || (gie && any_act);
    end
  end
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= PEI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= pei_resp(wr_sel);
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  wire logic [15:0] rd_val = (rd_sel == 3'h1) ? ev1_r :
                             (rd_sel == 3'h2) ? ev2_r :
                             (rd_sel == 3'h3) ? ev3_r :
                             (rd_sel == 3'h4) ? cfg_r : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= PEI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_val};
      rresp_r <= pei_resp(rd_sel);
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : pei_event_irq

// [pei_pkg.sv]
// Purpose: Shared constants and types for the event interrupt block
// Assumes: AXI4-Lite register access, 32-bit data, 16-bit registers
// Notes:   Register index times four gives the byte address
package pei_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] PEI_IDX_CFG = 12'h011;
  localparam logic [11:0] PEI_IDX_EV1 = 12'h012;
  localparam logic [11:0] PEI_IDX_EV2 = 12'h013;
  localparam logic [11:0] PEI_IDX_EV3 = 12'h018;
  localparam int PEI_AW = 14;
  localparam logic [13:0] PEI_ADDR_CFG = {PEI_IDX_CFG, 2'b00};
  localparam logic [13:0] PEI_ADDR_EV1 = {PEI_IDX_EV1, 2'b00};
  localparam logic [13:0] PEI_ADDR_EV2 = {PEI_IDX_EV2, 2'b00};
  localparam logic [13:0] PEI_ADDR_EV3 = {PEI_IDX_EV3, 2'b00};

  // ----------------------------------------------------------------
  // Field layouts: status bits and their enables
  // ----------------------------------------------------------------
  localparam logic [15:0] PEI_EV1_STS = 16'hEC00;
  localparam logic [15:0] PEI_EV1_EN = 16'h00EC;
  localparam logic [15:0] PEI_EV2_STS = 16'hCD00;
  localparam logic [15:0] PEI_EV2_EN = 16'h00CC;
  localparam logic [15:0] PEI_EV3_STS = 16'hCF00;
  localparam logic [15:0] PEI_EV3_EN = 16'h00CF;
  localparam int PEI_EN_SHIFT = 8;
  localparam int PEI_ONEHOT_BIT = 8;
  localparam int PEI_CFG_FORCE_BIT = 2;
  localparam int PEI_CFG_GIE_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PEI_EV1_RST = 16'h0000;
  localparam logic [15:0] PEI_EV2_RST = 16'h0000;
  localparam logic [15:0] PEI_EV3_RST = 16'h0008;
  localparam logic [15:0] PEI_CFG_RST = 16'h0000;
  localparam logic [15:0] PEI_CFG_MASK = 16'h0006;

  // ----------------------------------------------------------------
  // AXI response codes and event carrier
  // ----------------------------------------------------------------
  localparam logic [1:0] PEI_RESP_OKAY = 2'h0;
  localparam logic [1:0] PEI_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic link_quality_low;
    logic energy_detect_change;
    logic link_change;
    logic esd_fault;
    logic training_done;
    logic undervoltage;
    logic overvoltage;
    logic overtemperature;
    logic sleep_change;
    logic not_one_hot;
    logic ops_ack_received;
    logic ops_channel_transmit_pending_clr;
    logic power_up_done;
    logic no_frame;
    logic wake_request;
    logic low_power_sleep_signal;
  } pei_events_s;

endpackage : pei_pkg

// [pei_event_irq_sva.sv]
// Purpose: Bus and readback checks on the event interrupt block
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the top module ports
`timescale 1ns/10ps
module pei_event_irq_sva
  import pei_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [PEI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  input wire logic irq
);
  // ------------------------------------------------------------
  // Readable bits of the last address taken
  // ------------------------------------------------------------
  logic [PEI_AW-1:0] ra_r;
  wire logic [15:0] ok_mask =
    (ra_r == PEI_ADDR_EV1) ? (PEI_EV1_STS | PEI_EV1_EN) :
    (ra_r == PEI_ADDR_EV2) ? (PEI_EV2_STS | PEI_EV2_EN) :
    (ra_r == PEI_ADDR_EV3) ? (PEI_EV3_STS | PEI_EV3_EN) :
    (ra_r == PEI_ADDR_CFG) ? PEI_CFG_MASK : 16'h0000;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_AR_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered next cycle");
  AST_AR_STALL: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
  AST_R_UPPER: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper half not zero");
  AST_RSVD: assert property (s_axi_rvalid |->
    (s_axi_rdata[15:0] & ~ok_mask) == 16'h0000)
    else $error("reserved bit read as one");
  AST_UNMAP: assert property (s_axi_rvalid && ok_mask == 16'h0000 |->
    s_axi_rresp == PEI_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  AST_AW_BUSY: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("second write address taken");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_IRQ: cover property ($rose(irq));
endmodule : pei_event_irq_sva

bind pei_event_irq pei_event_irq_sva pei_event_irq_sva_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);

// [pei_host_irq.sv]
// Purpose: Host interrupt input seen by the processor
// Assumes: Level interrupt, sampled on aclk
// Notes:   One cycle of input sync, as a real host would add
`timescale 1ns/10ps
module pei_host_irq (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt pin and what the host sees
  input wire logic irq,
  output logic irq_seen_r
);
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_seen_r <= 1'b0;
    else irq_seen_r <= irq;
  end
endmodule : pei_host_irq

// [pei_tb.sv]
// Purpose: Self-checking bench for the event interrupt block
// Assumes: AXI4-Lite master in the bench, host model on irq
// Notes:   Event vector follows the struct order, MSB first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench
  import pei_pkg::*;
;
  localparam logic [13:0] ADR [3] = '{PEI_ADDR_EV1, PEI_ADDR_EV2, PEI_ADDR_EV3};
  localparam logic [15:0] STS [3] = '{PEI_EV1_STS, PEI_EV2_STS, PEI_EV3_STS};
  localparam logic [15:0] EN [3] = '{PEI_EV1_EN, PEI_EV2_EN, PEI_EV3_EN};
  localparam logic [15:0] RST [3] = '{16'h0000, 16'h0000, 16'h0008};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [PEI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic irq, irq_seen_r;
  pei_events_s events = '0;
  int n_mismatch = 0, num_checks = 0;
  always #2 aclk = ~aclk;
  pei_event_irq pei_event_irq_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .events, .irq);
  pei_host_irq pei_host_irq_i (.aclk, .aresetn, .irq, .irq_seen_r);
  // ------------------------------------------------------------
  // Bus and helper tasks
  // ------------------------------------------------------------
  task stop_test;
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task guard(input int n);
    if (n >= 50) begin
      `CHK("timeout", 1'b0, 1'b1)
      stop_test();
    end
  endtask : guard
  task wr(input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    // Ready stays high after the call; the next call drives it high again
    rs = s_axi_bresp;
    guard(n);
  endtask : wr
  task rd(input logic [13:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    guard(n);
  endtask : rd
  // Irq is registered and the host adds a stage, so allow four edges
  task pulse(input logic [15:0] v);
    events <= pei_events_s'(v);
    @(posedge aclk);
    events <= '0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(ADR[i]);
      `CHK("reset", {16'h0000, RST[i]}, rv)
      wr(ADR[i], 16'hFFFF);
      `CHK("wresp", PEI_RESP_OKAY, rs)
      rd(ADR[i]);
      `CHK("enables", {16'h0000, EN[i]}, rv)
      `CHK("resp", PEI_RESP_OKAY, rs)
    end
    pulse(16'hFFFF);
    `CHK("irq_gie_off", 1'b0, irq_seen_r)
    for (int i = 0; i < 3; i++) begin
      rd(ADR[i]);
      `CHK("status", {16'h0000, STS[i] | EN[i]}, rv)
      rd(ADR[i]);
      `CHK("cleared", {16'h0000, EN[i]}, rv)
      wr(ADR[i], RST[i]);
    end
  endtask : t_regs
  task t_unmapped;
    wr(14'h0050, 16'hFFFF);
    `CHK("wr_unmapped", PEI_RESP_SLVERR, rs)
    rd(14'h0050);
    `CHK("rd_unmapped", PEI_RESP_SLVERR, rs)
    `CHK("rd_unmapped_data", 32'h00000000, rv)
  endtask : t_unmapped
  task t_irq;
    wr(PEI_ADDR_EV1, 16'h0080);
    pulse(16'h8000);
    `CHK("irq_masked_global", 1'b0, irq_seen_r)
    wr(PEI_ADDR_CFG, 16'h0002);
    repeat (3) @(posedge aclk);
    `CHK("irq_link_quality", 1'b1, irq_seen_r)
    rd(PEI_ADDR_EV1);
    `CHK("ev1_read", 32'h00008080, rv)
    repeat (3) @(posedge aclk);
    `CHK("irq_after_clear", 1'b0, irq_seen_r)
    wr(PEI_ADDR_EV1, 16'h0000);
    pulse(16'h8000);
    `CHK("irq_enable_off", 1'b0, irq_seen_r)
    rd(PEI_ADDR_EV1);
    pulse(16'h0008);
    `CHK("irq_power_up", 1'b1, irq_seen_r)
    rd(PEI_ADDR_EV3);
    `CHK("ev3_read", 32'h00000808, rv)
    pulse(16'h0040);
    `CHK("irq_one_hot", 1'b1, irq_seen_r)
    rd(PEI_ADDR_EV2);
    `CHK("ev2_read", 32'h00000100, rv)
    wr(PEI_ADDR_CFG, 16'h0004);
    repeat (3) @(posedge aclk);
    `CHK("irq_forced", 1'b1, irq_seen_r)
  endtask : t_irq
  task t_reset;
    wr(PEI_ADDR_EV3, 16'h0000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PEI_ADDR_EV3);
    `CHK("ev3_after_reset", {16'h0000, PEI_EV3_RST}, rv)
    `CHK("irq_after_reset", 1'b0, irq_seen_r)
  endtask : t_reset
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_unmapped();
    t_irq();
    t_reset();
    stop_test();
  end
endmodule : testbench
